// ===== hw/dcar_pkg.sv
// Shared constants and carrier types for the DMA channel address and size block.
package dcar_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] DCAR_OFF_SRC_START = 8'h00;
    localparam logic [7:0] DCAR_OFF_DST_START = 8'h04;
    localparam logic [7:0] DCAR_OFF_SRC_SIZE  = 8'h08;
    localparam logic [7:0] DCAR_OFF_DST_SIZE  = 8'h0c;
    localparam logic [7:0] DCAR_OFF_SRC_PTR   = 8'h10;
    localparam logic [7:0] DCAR_OFF_DST_PTR   = 8'h14;
    localparam logic [7:0] DCAR_OFF_CTRL      = 8'h18;
    localparam logic [7:0] DCAR_OFF_IRQ_STAT  = 8'h1c;
    localparam logic [7:0] DCAR_OFF_IRQ_MASK  = 8'h20;

    // ------------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------------
    localparam int          DCAR_SIZE_W          = 16;
    localparam int          DCAR_CTRL_PAT_MODE   = 0;
    localparam int          DCAR_CTRL_RESTART    = 1;
    localparam int          DCAR_IRQ_SRC_DONE    = 7;
    localparam int          DCAR_IRQ_SRC_HALF    = 6;
    localparam int          DCAR_IRQ_BLOCK_DONE  = 3;
    localparam logic [7:0]  DCAR_IRQ_IMPL_MASK   = 8'hc8;
    localparam logic [31:0] DCAR_RST_WORD        = 32'h0000_0000;
    localparam logic [15:0] DCAR_RST_SIZE        = 16'h0000;
    localparam logic [7:0]  DCAR_RST_IRQ         = 8'h00;
    localparam logic [1:0]  DCAR_RESP_OKAY       = 2'b00;
    localparam logic [1:0]  DCAR_RESP_SLVERR     = 2'b10;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [31:0] src_start_addr;
        logic [31:0] dst_start_addr;
        logic [15:0] src_byte_size;
        logic [15:0] dst_byte_size;
    } dcar_cfg_t;

    typedef struct packed {
        logic src_done_flag;
        logic src_half_flag;
        logic block_complete_flag;
    } dcar_evt_t;

endpackage : dcar_pkg

// ===== hw/dcar_ptr_track.sv
// Source and destination byte pointers with end, midpoint and block events.
`timescale 1ns/1ns
module dcar_ptr_track #(
    parameter int SIZE_W = 16
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire dcar_pkg::dcar_cfg_t cfg,
    input  wire logic              byte_moved,
    input  wire logic              pattern_match,
    input  wire logic              pattern_mode,
    input  wire logic              restart,
    output logic [SIZE_W-1:0]      src_byte_ptr,
    output logic [SIZE_W-1:0]      dst_byte_ptr,
    output dcar_pkg::dcar_evt_t    evt
);
    import dcar_pkg::*;

    logic [SIZE_W-1:0] src_ptr_q;
    logic [SIZE_W-1:0] dst_ptr_q;
    logic [SIZE_W-1:0] xfer_q;
    dcar_evt_t         evt_q;

    wire logic [SIZE_W-1:0] src_inc   = src_ptr_q + 1'b1;
    wire logic [SIZE_W-1:0] dst_inc   = dst_ptr_q + 1'b1;
    wire logic [SIZE_W-1:0] xfer_inc  = xfer_q + 1'b1;
    wire logic [SIZE_W-1:0] src_half  = cfg.src_byte_size >> 1;
    wire logic [SIZE_W-1:0] blk_len   = (cfg.src_byte_size > cfg.dst_byte_size) ?
                                        cfg.src_byte_size : cfg.dst_byte_size;
    wire logic              src_end   = byte_moved && (src_inc == cfg.src_byte_size); // R8
    wire logic              src_mid   = byte_moved && (src_half != '0)
                                        && (src_inc == src_half);                  // R8
    wire logic              pat_hit   = pattern_mode && pattern_match;
    wire logic              blk_end   = (byte_moved && (xfer_inc == blk_len)) || pat_hit; // R9
    wire logic              dst_end   = byte_moved && (dst_inc == cfg.dst_byte_size);

    always_ff @(posedge aclk) begin
        if (!aresetn || restart || pat_hit || blk_end) begin
            src_ptr_q <= '0; // R10
            dst_ptr_q <= '0;
            xfer_q    <= '0;
        end else if (byte_moved) begin
            src_ptr_q <= src_end ? '0 : src_inc; // R10
            dst_ptr_q <= dst_end ? '0 : dst_inc;
            xfer_q    <= xfer_inc;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            evt_q <= '0;
        end else begin
            evt_q.src_done_flag       <= src_end;
            evt_q.src_half_flag       <= src_mid;
            evt_q.block_complete_flag <= blk_end;
        end
    end

    assign src_byte_ptr = src_ptr_q;
    assign dst_byte_ptr = dst_ptr_q;
    assign evt          = evt_q;

endmodule : dcar_ptr_track

// ===== hw/dcar_top.sv
// AXI4-Lite register file of one DMA channel: addresses, sizes, pointers, interrupt.
//
// Notes on behaviour
// R1 - Source start address: full 32-bit read/write.
// R2 - Software loads physical source addresses only.
// R3 - Destination start address: 32-bit read/write, resets zero.
// R4 - Software loads physical destination addresses only.
// R5 - Source size: 16-bit byte count, low half.
// R6 - Upper sixteen bits read zero, ignore writes.
// R7 - Destination size: 16-bit byte count, resets zero.
// R8 - Flag source done and source half events.
// R9 - Block complete at larger size or pattern.
// R10 - Source pointer read-only, cleared on pattern.
`timescale 1ns/1ns
module dcar_top #(
    parameter int ADDR_W = 8
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              byte_moved,
    input  wire logic              pattern_match,
    output dcar_pkg::dcar_cfg_t    cfg,
    output logic                   pattern_mode,
    output logic [15:0]            src_byte_ptr,
    output logic [15:0]            dst_byte_ptr,
    output logic                   irq
);
    import dcar_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    dcar_cfg_t         cfg_q;
    logic              pat_mode_q;
    logic [7:0]        stat_q;
    logic [7:0]        mask_q;
    logic              irq_q;
    logic              awready_q;
    logic              wready_q;
    logic              arready_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0]       wdata_q;
    logic [3:0]        wstrb_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic              rvalid_q;
    logic [31:0]       rdata_q;
    logic [1:0]        rresp_q;
    logic              restart_q;
    logic [15:0]       sptr;
    logic [15:0]       dptr;
    dcar_evt_t         evt;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction : merge

    wire logic [7:0]  waddr    = 8'(awaddr_q);
    wire logic [7:0]  raddr    = 8'(s_axi_araddr);
    wire logic        do_write = !awready_q && !wready_q && !bvalid_q;
    wire logic        do_read  = s_axi_arvalid && arready_q;
    wire logic        wr_ssa   = do_write && (waddr == DCAR_OFF_SRC_START);
    wire logic        wr_dsa   = do_write && (waddr == DCAR_OFF_DST_START);
    wire logic        wr_ssz   = do_write && (waddr == DCAR_OFF_SRC_SIZE);
    wire logic        wr_dsz   = do_write && (waddr == DCAR_OFF_DST_SIZE);
    wire logic        wr_ctl   = do_write && (waddr == DCAR_OFF_CTRL);
    wire logic        wr_msk   = do_write && (waddr == DCAR_OFF_IRQ_MASK);
    wire logic        wr_ro    = (waddr == DCAR_OFF_SRC_PTR) || (waddr == DCAR_OFF_DST_PTR)
                                 || (waddr == DCAR_OFF_IRQ_STAT);
    wire logic        wr_ok    = wr_ssa || wr_dsa || wr_ssz || wr_dsz || wr_ctl || wr_msk
                                 || (do_write && wr_ro);
    wire logic [31:0] wmerged_ctl = merge({30'h0, 1'b0, pat_mode_q}, wdata_q, wstrb_q);
    wire logic [31:0] wmerged_msk = merge({24'h0, mask_q}, wdata_q, wstrb_q);
    wire logic [31:0] wm_ssz      = merge({16'h0, cfg_q.src_byte_size}, wdata_q, wstrb_q);
    wire logic [31:0] wm_dsz      = merge({16'h0, cfg_q.dst_byte_size}, wdata_q, wstrb_q);
    wire logic        rd_stat     = do_read && (raddr == DCAR_OFF_IRQ_STAT);

    logic [31:0] rd_word;
    logic        rd_hit;
    always_comb begin
        rd_hit  = 1'b1;
        rd_word = DCAR_RST_WORD;
        if (raddr == DCAR_OFF_SRC_START) begin
            rd_word = cfg_q.src_start_addr;          // R1
        end else if (raddr == DCAR_OFF_DST_START) begin
            rd_word = cfg_q.dst_start_addr;          // R3
        end else if (raddr == DCAR_OFF_SRC_SIZE) begin
            rd_word = {16'h0, cfg_q.src_byte_size};  // R6
        end else if (raddr == DCAR_OFF_DST_SIZE) begin
            rd_word = {16'h0, cfg_q.dst_byte_size};  // R6
        end else if (raddr == DCAR_OFF_SRC_PTR) begin
            rd_word = {16'h0, sptr};                 // R6
        end else if (raddr == DCAR_OFF_DST_PTR) begin
            rd_word = {16'h0, dptr};
        end else if (raddr == DCAR_OFF_CTRL) begin
            rd_word = {31'h0, pat_mode_q};
        end else if (raddr == DCAR_OFF_IRQ_STAT) begin
            rd_word = {24'h0, stat_q};
        end else if (raddr == DCAR_OFF_IRQ_MASK) begin
            rd_word = {24'h0, mask_q};
        end else begin
            rd_hit  = 1'b0;
        end
    end

    // Events set their bits even in the cycle the status is read, so none are lost.
    wire logic [7:0] evt_bits = ({7'h0, evt.src_done_flag} << DCAR_IRQ_SRC_DONE)
                              | ({7'h0, evt.src_half_flag} << DCAR_IRQ_SRC_HALF)
                              | ({7'h0, evt.block_complete_flag} << DCAR_IRQ_BLOCK_DONE);
    wire logic [7:0] stat_d   = (rd_stat ? 8'h00 : stat_q) | evt_bits;

    // ------------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            awaddr_q  <= '0;
            wdata_q   <= DCAR_RST_WORD;
            wstrb_q   <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= DCAR_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && awready_q) begin
                awready_q <= 1'b0;
                awaddr_q  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && wready_q) begin
                wready_q <= 1'b0;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            if (do_write) begin
                bvalid_q <= 1'b1;
                bresp_q  <= wr_ok ? DCAR_RESP_OKAY : DCAR_RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready) begin
                // Both channels reopen only once the answer is taken, so one write is in flight.
                bvalid_q  <= 1'b0;
                awready_q <= 1'b1;
                wready_q  <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_q      <= '0; // R3 R7
            pat_mode_q <= 1'b0;
            mask_q     <= DCAR_RST_IRQ;
            stat_q     <= DCAR_RST_IRQ;
            irq_q      <= 1'b0;
            restart_q  <= 1'b0;
        end else begin
            if (wr_ssa) begin
                cfg_q.src_start_addr <= merge(cfg_q.src_start_addr, wdata_q, wstrb_q); // R1
            end
            if (wr_dsa) begin
                cfg_q.dst_start_addr <= merge(cfg_q.dst_start_addr, wdata_q, wstrb_q); // R3
            end
            if (wr_ssz) begin
                cfg_q.src_byte_size <= wm_ssz[15:0]; // R5 R6
            end
            if (wr_dsz) begin
                cfg_q.dst_byte_size <= wm_dsz[15:0]; // R7 R6
            end
            if (wr_ctl) begin
                pat_mode_q <= wmerged_ctl[DCAR_CTRL_PAT_MODE];
            end
            if (wr_msk) begin
                mask_q <= wmerged_msk[7:0] & DCAR_IRQ_IMPL_MASK;
            end
            restart_q <= wr_ctl && wstrb_q[0] && wdata_q[DCAR_CTRL_RESTART];
            stat_q    <= stat_d;
            irq_q     <= |(stat_d & mask_q);
        end
    end

    // ------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= DCAR_RST_WORD;
            rresp_q   <= DCAR_RESP_OKAY;
        end else if (do_read) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= rd_word;
            rresp_q   <= rd_hit ? DCAR_RESP_OKAY : DCAR_RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Pointer tracking
    // ------------------------------------------------------------------
    dcar_ptr_track #(
        .SIZE_W        (DCAR_SIZE_W)
    ) u_track (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .cfg           (cfg_q),
        .byte_moved    (byte_moved),
        .pattern_match (pattern_match),
        .pattern_mode  (pat_mode_q),
        .restart       (restart_q),
        .src_byte_ptr  (sptr),
        .dst_byte_ptr  (dptr),
        .evt           (evt)
    );

    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    assign cfg           = cfg_q;
    assign pattern_mode  = pat_mode_q;
    assign src_byte_ptr  = sptr;
    assign dst_byte_ptr  = dptr;
    assign irq           = irq_q;

endmodule : dcar_top

// ===== dv/dcar_chk.sv
// Concurrent checks on the register port and pointer outputs of the channel block.
`timescale 1ns/1ns
module dcar_chk (
    input wire logic                aclk,
    input wire logic                aresetn,
    input wire logic                s_axi_awready,
    input wire logic                s_axi_wready,
    input wire logic                s_axi_bvalid,
    input wire logic                s_axi_bready,
    input wire logic [1:0]          s_axi_bresp,
    input wire logic                s_axi_arvalid,
    input wire logic                s_axi_arready,
    input wire logic                s_axi_rvalid,
    input wire logic                s_axi_rready,
    input wire logic [31:0]         s_axi_rdata,
    input wire logic                byte_moved,
    input wire logic                pattern_match,
    input wire logic                pattern_mode,
    input wire dcar_pkg::dcar_cfg_t cfg,
    input wire logic [15:0]         src_byte_ptr,
    input wire logic [15:0]         dst_byte_ptr,
    input wire logic                irq
);
    import dcar_pkg::*;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write channels open while a response is pending");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
    a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
    a_cfg_hold: assert property (!$rose(s_axi_bvalid) |-> $stable(cfg))
        else $error("configuration changed without a write");
    a_ptr_step: assert property (byte_moved && !(pattern_match && pattern_mode) |=>
        src_byte_ptr == $past(src_byte_ptr) + 16'h1 || src_byte_ptr == 16'h0)
        else $error("source pointer did not step by one byte");
    a_pat_clear: assert property (pattern_match && pattern_mode |=>
        src_byte_ptr == 16'h0 && dst_byte_ptr == 16'h0)
        else $error("pointers not cleared on pattern hit");
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_irq: cover property ($rose(irq));
endmodule : dcar_chk

bind dcar_top dcar_chk i_dcar_chk (.aclk, .aresetn, .s_axi_awready, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .byte_moved, .pattern_match,
    .pattern_mode, .cfg, .src_byte_ptr, .dst_byte_ptr, .irq);

// ===== dv/dcar_eng_model.sv
// Transfer engine stand-in that reports moved bytes and pattern hits.
`timescale 1ns/1ns
module dcar_eng_model (
    input wire logic aclk,
    output logic     byte_moved,
    output logic     pattern_match
);
    initial begin
        byte_moved = 1'b0;
        pattern_match = 1'b0;
    end
    // One pulse per byte; gap sets how slowly the engine works.
    task automatic burst(input int n, input int gap);
        repeat (n) begin
            @(posedge aclk);
            byte_moved <= 1'b1;
            @(posedge aclk);
            byte_moved <= 1'b0;
            repeat (gap) @(posedge aclk);
        end
    endtask : burst
    task automatic hit();
        @(posedge aclk);
        pattern_match <= 1'b1;
        @(posedge aclk);
        pattern_match <= 1'b0;
    endtask : hit
endmodule : dcar_eng_model

// ===== dv/dcar_tb_top.sv
// Self-checking bench for the channel address and size register block.
`timescale 1ns/1ns
module dcar_tb_top;
    import dcar_pkg::*;
    logic aclk = 0, aresetn = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, byte_moved, pattern_match, pattern_mode, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [15:0] src_byte_ptr, dst_byte_ptr;
    dcar_cfg_t cfg;
    int miscompares = 0, cmp_count = 0;
    always #20 aclk = ~aclk;
    dcar_top i_dcar_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .byte_moved,
        .pattern_match, .cfg, .pattern_mode, .src_byte_ptr, .dst_byte_ptr, .irq);
    dcar_eng_model i_dcar_eng_model (.aclk, .byte_moved, .pattern_match);
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_ok, w_ok;
        aw_ok = 0;
        w_ok = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        forever begin
            @(posedge aclk);
            if (aw_ok && w_ok && s_axi_bvalid === 1'b1) break;
            if (!aw_ok && s_axi_awready === 1'b1) begin aw_ok = 1; s_axi_awvalid <= 0; end
            if (!w_ok && s_axi_wready === 1'b1) begin w_ok = 1; s_axi_wvalid <= 0; end
        end
        s_axi_bready <= 0;
        chk(32'(s_axi_bresp), 32'(er));
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        logic ar_ok;
        ar_ok = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        forever begin
            @(posedge aclk);
            if (ar_ok && s_axi_rvalid === 1'b1) break;
            if (!ar_ok && s_axi_arready === 1'b1) begin ar_ok = 1; s_axi_arvalid <= 0; end
        end
        s_axi_rready <= 0;
        chk(s_axi_rdata, e);
        chk(32'(s_axi_rresp), 32'(er));
    endtask : rd
    task automatic t_reset();
        logic [7:0] offs [7];
        offs = '{DCAR_OFF_SRC_START, DCAR_OFF_DST_START, DCAR_OFF_SRC_SIZE,
                 DCAR_OFF_DST_SIZE, DCAR_OFF_SRC_PTR, DCAR_OFF_DST_PTR, DCAR_OFF_IRQ_STAT};
        foreach (offs[i]) rd(offs[i], DCAR_RST_WORD, DCAR_RESP_OKAY);
        chk(32'(irq), 32'h0);
    endtask : t_reset
    task automatic t_regs();
        // Physical bus addresses only; the block passes them on untranslated.
        wr(DCAR_OFF_SRC_START, 32'hfedc_ba98, DCAR_RESP_OKAY);
        wr(DCAR_OFF_DST_START, 32'h8000_0001, DCAR_RESP_OKAY);
        wr(DCAR_OFF_SRC_SIZE, 32'hffff_ffff, DCAR_RESP_OKAY);
        wr(DCAR_OFF_DST_SIZE, 32'h5a5a_ffff, DCAR_RESP_OKAY);
        rd(DCAR_OFF_SRC_START, 32'hfedc_ba98, DCAR_RESP_OKAY);
        rd(DCAR_OFF_DST_START, 32'h8000_0001, DCAR_RESP_OKAY);
        rd(DCAR_OFF_SRC_SIZE, 32'h0000_ffff, DCAR_RESP_OKAY);
        rd(DCAR_OFF_DST_SIZE, 32'h0000_ffff, DCAR_RESP_OKAY);
        chk(cfg.src_start_addr, 32'hfedc_ba98);
        chk(cfg.dst_start_addr, 32'h8000_0001);
        chk({cfg.src_byte_size, cfg.dst_byte_size}, 32'hffff_ffff);
        wr(DCAR_OFF_SRC_PTR, 32'hffff_ffff, DCAR_RESP_OKAY);
        rd(DCAR_OFF_SRC_PTR, 32'h0, DCAR_RESP_OKAY);
        wr(8'h40, 32'h1, DCAR_RESP_SLVERR);
        rd(8'h40, 32'h0, DCAR_RESP_SLVERR);
    endtask : t_regs
    task automatic t_events();
        wr(DCAR_OFF_SRC_SIZE, 32'h4, DCAR_RESP_OKAY);
        wr(DCAR_OFF_DST_SIZE, 32'h6, DCAR_RESP_OKAY);
        wr(DCAR_OFF_IRQ_MASK, 32'h08, DCAR_RESP_OKAY);
        i_dcar_eng_model.burst(3, 0);
        repeat (4) @(posedge aclk);
        chk(32'(src_byte_ptr), 32'h3);
        chk(32'(irq), 32'h0);
        rd(DCAR_OFF_IRQ_STAT, 32'h40, DCAR_RESP_OKAY);
        wr(DCAR_OFF_IRQ_MASK, 32'hc8, DCAR_RESP_OKAY);
        i_dcar_eng_model.burst(3, 2);
        repeat (4) @(posedge aclk);
        chk(32'(irq), 32'h1);
        chk({src_byte_ptr, dst_byte_ptr}, 32'h0);
        // After the wrap the third byte passes the source midpoint once more.
        rd(DCAR_OFF_IRQ_STAT, 32'hc8, DCAR_RESP_OKAY);
        rd(DCAR_OFF_IRQ_STAT, 32'h00, DCAR_RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk(32'(irq), 32'h0);
    endtask : t_events
    task automatic t_pattern();
        wr(DCAR_OFF_CTRL, 32'h1, DCAR_RESP_OKAY);
        rd(DCAR_OFF_CTRL, 32'h1, DCAR_RESP_OKAY);
        chk(32'(pattern_mode), 32'h1);
        i_dcar_eng_model.burst(2, 0);
        i_dcar_eng_model.hit();
        repeat (4) @(posedge aclk);
        chk({src_byte_ptr, dst_byte_ptr}, 32'h0);
        // The second byte reaches the source midpoint before the hit.
        rd(DCAR_OFF_IRQ_STAT, 32'h48, DCAR_RESP_OKAY);
        i_dcar_eng_model.burst(1, 0);
        repeat (2) @(posedge aclk);
        chk(32'(src_byte_ptr), 32'h1);
        wr(DCAR_OFF_CTRL, 32'h3, DCAR_RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk(32'(src_byte_ptr), 32'h0);
    endtask : t_pattern
    task automatic stop_test();
        if (miscompares == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1;
        t_reset();
        t_regs();
        t_events();
        t_pattern();
        stop_test();
    end
    initial begin
        repeat (3000) @(posedge aclk);
        miscompares++;
        stop_test();
    end
endmodule : dcar_tb_top
